// [pkg/nv_access_pkg.sv]
/*
  Shared constants of the byte-wide nonvolatile access controller:
  register offsets, control field positions, mode codes and the
  timing counts derived from the 100 MHz bus clock.
  Assumes a single hclk domain and 32-bit AHB-Lite register words.
*/
package nv_access_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;

  // Control register field positions
  localparam int BIT_READ_STROBE = 0;
  localparam int BIT_PROG_STROBE = 1;
  localparam int BIT_PROG_ARM = 2;
  localparam int BIT_READY_IRQ_EN = 3;
  localparam int BIT_OP_MODE_LOW = 4;
  localparam int BIT_OP_MODE_HIGH = 5;

  // Status and mask register bit positions
  localparam int STAT_W = 2;
  localparam int STAT_PROG_DONE = 0;
  localparam int STAT_STROBE_REFUSED = 1;

  // Operation mode codes
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // Geometry and reset values
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int DEPTH = 512;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [8:0] ADDR_RESET = 9'h000;

  // Timing: printed times in ns, counts derived from the clock period
  localparam int CLK_PERIOD_NS = 10;
  localparam int ATOMIC_TIME_NS = 3400000;
  localparam int SPLIT_TIME_NS = 1800000;
  localparam int ATOMIC_CYCLES = ATOMIC_TIME_NS / CLK_PERIOD_NS;
  localparam int SPLIT_CYCLES = SPLIT_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 19;
  localparam int ARM_WINDOW_CYCLES = 4;
  localparam int PROG_STALL_CYCLES = 2;
  localparam int READ_STALL_CYCLES = 4;
  localparam int CNT_W = 3;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int HTRANS_ACTIVE_BIT = 1;

endpackage

// [verilog/nv_access_control.sv]
/*
  Byte-wide nonvolatile data memory access controller with an
  AHB-Lite register slave, a timed arm-then-strobe programming
  engine, CPU stall through hreadyout and a ready interrupt.
  Assumes one master, single word transfers, hready tied to our
  hreadyout, and a power-on reset that precedes any use.
*/
// The AHB-Lite slave port and the address map were decided locally.
//
// Functional notes
// - mode field selects action launched by strobe
// - atomic 3.4ms, erase or write 1.8ms
// - mode writes ignored while strobe bit set
// - reset clears mode unless programming busy
// - ready interrupt level while enabled and idle
// - arm bit self-clears four cycles after set
// - strobe starts programming only while armed
// - strobe bit held until programming time ends
// - program strobe stalls CPU two cycles
// - read strobe loads data register at once
// - read strobe stalls CPU four cycles
// - busy blocks reads and address changes
// - data register feeds writes, receives reads
// - nine-bit linear address, high and low bytes; here one nine-bit field in the word at OFS_ADDR
`timescale 1ns/1ps
module nv_access_control #(
  parameter int ATOMIC_CYCLES = nv_access_pkg::ATOMIC_CYCLES,
  parameter int SPLIT_CYCLES = nv_access_pkg::SPLIT_CYCLES
) (
  input wire logic hclk, // Bus and engine clock
  input wire logic hresetn, // System reset, active low
  input wire logic por_n, // Power-on reset of the engine, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic global_irq_en, // Core flag register I-bit
  output logic hreadyout, // Low while the CPU is stalled
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  output logic irq // Level interrupt
);

  localparam int TW = nv_access_pkg::TIMER_W;
  localparam int CW = nv_access_pkg::CNT_W;
  localparam int AW = nv_access_pkg::ADDR_W;
  localparam int DW = nv_access_pkg::DATA_W;
  localparam int SW = nv_access_pkg::STAT_W;

  typedef enum logic [1:0] {ENG_IDLE, ENG_BUSY} eng_state_t;

  // Address decode shared by read capture and write effects
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Programming duration per mode
  function automatic logic [TW-1:0] prog_cycles(input logic [1:0] m);
    if (m == nv_access_pkg::MODE_ATOMIC) begin
      prog_cycles = TW'(ATOMIC_CYCLES);
    end else begin
      prog_cycles = TW'(SPLIT_CYCLES);
    end
  endfunction

  // Bus pipeline state
  logic dp_valid_r;
  logic dp_write_r;
  logic [7:0] dp_addr_r;
  logic applied_r;
  logic [CW-1:0] stall_cnt_r;
  logic [31:0] rdata_r;

  // Software-facing registers
  logic arm_r;
  logic [CW-1:0] arm_cnt_r;
  logic ready_irq_enable_r;
  logic [AW-1:0] nv_byte_address_r;
  logic [DW-1:0] nv_byte_value_r;
  logic [SW-1:0] stat_r;
  logic [SW-1:0] mask_r;

  // Engine state, survives system reset except the mode field, which clears when idle
  eng_state_t eng_state_r;
  logic [1:0] op_mode_r;
  logic [1:0] op_r;
  logic [TW-1:0] timer_r;
  logic [AW-1:0] prog_addr_r;
  logic [DW-1:0] prog_data_r;
  logic [DW-1:0] array_r [nv_access_pkg::DEPTH];

  // Decoded effects of the current data phase
  logic busy;
  logic act;
  logic wr_ctrl;
  logic [1:0] new_mode;
  logic prog_req;
  logic prog_go;
  logic strobe_refused;
  logic rd_req;
  logic stall_now;
  logic prog_done;
  logic [SW-1:0] stat_set;

  assign busy = (eng_state_r == ENG_BUSY);
  // Effects apply once, in the first data phase cycle
  assign act = dp_valid_r & dp_write_r & ~applied_r;
  assign wr_ctrl = act & hit(dp_addr_r, nv_access_pkg::OFS_CTRL);
  assign new_mode = hwdata[nv_access_pkg::BIT_OP_MODE_HIGH:
                           nv_access_pkg::BIT_OP_MODE_LOW];
  // Strobe counts only while armed and idle
  assign prog_req = wr_ctrl & hwdata[nv_access_pkg::BIT_PROG_STROBE] &
                    arm_r & ~busy;
  // Reserved code never starts, strobe bit never sets
  assign prog_go = prog_req & (new_mode != nv_access_pkg::MODE_RSVD);
  assign strobe_refused = wr_ctrl & ~busy & ~arm_r &
                          hwdata[nv_access_pkg::BIT_PROG_STROBE];
  // Reads are blocked during programming
  assign rd_req = wr_ctrl & hwdata[nv_access_pkg::BIT_READ_STROBE] &
                  ~busy;
  assign stall_now = prog_go | rd_req;
  assign hreadyout = ~(stall_now | (stall_cnt_r != '0));
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign prog_done = busy & (timer_r == TW'(1));
  assign stat_set = {strobe_refused, prog_done};

  // Address phase capture; a stalled data phase holds the pipeline
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else if (hready) begin
      dp_valid_r <= hsel & htrans[nv_access_pkg::HTRANS_ACTIVE_BIT];
      dp_write_r <= hwrite;
      dp_addr_r <= haddr[7:0];
    end
  end

  // Marks a data phase whose effects are already taken
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      applied_r <= 1'b0;
    end else begin
      applied_r <= dp_valid_r & ~hreadyout;
    end
  end

  // CPU stall: the strobe write's data phase is stretched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stall_cnt_r <= '0;
    end else if (rd_req) begin
      stall_cnt_r <= CW'(nv_access_pkg::READ_STALL_CYCLES - 1);
    end else if (prog_go) begin
      stall_cnt_r <= CW'(nv_access_pkg::PROG_STALL_CYCLES - 1);
    end else if (stall_cnt_r != '0) begin
      stall_cnt_r <= stall_cnt_r - CW'(1);
    end
  end

  // Read data captured at the address phase, unmapped reads give zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= 32'h00000000;
    end else if (hready & hsel & ~hwrite &
                 htrans[nv_access_pkg::HTRANS_ACTIVE_BIT]) begin
      rdata_r <= 32'h00000000;
      if (hit(haddr[7:0], nv_access_pkg::OFS_CTRL)) begin
        rdata_r[nv_access_pkg::BIT_OP_MODE_HIGH:
                nv_access_pkg::BIT_OP_MODE_LOW] <= op_mode_r;
        rdata_r[nv_access_pkg::BIT_READY_IRQ_EN] <= ready_irq_enable_r;
        rdata_r[nv_access_pkg::BIT_PROG_ARM] <= arm_r;
        rdata_r[nv_access_pkg::BIT_PROG_STROBE] <= busy;
      end
      if (hit(haddr[7:0], nv_access_pkg::OFS_ADDR)) begin
        rdata_r[AW-1:0] <= nv_byte_address_r;
      end
      if (hit(haddr[7:0], nv_access_pkg::OFS_DATA)) begin
        rdata_r[DW-1:0] <= nv_byte_value_r;
      end
      if (hit(haddr[7:0], nv_access_pkg::OFS_STAT)) begin
        rdata_r[SW-1:0] <= stat_r;
      end
      if (hit(haddr[7:0], nv_access_pkg::OFS_MASK)) begin
        rdata_r[SW-1:0] <= mask_r;
      end
    end
  end

  // Arm bit with its own four-cycle window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_r <= 1'b0;
      arm_cnt_r <= '0;
    end else if (wr_ctrl & hwdata[nv_access_pkg::BIT_PROG_ARM]) begin
      arm_r <= 1'b1;
      arm_cnt_r <= CW'(nv_access_pkg::ARM_WINDOW_CYCLES - 1);
    end else if (arm_r) begin
      if (arm_cnt_r == '0) begin
        arm_r <= 1'b0;
      end else begin
        arm_cnt_r <= arm_cnt_r - CW'(1);
      end
    end
  end

  // Interrupt enable for the ready level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_irq_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      ready_irq_enable_r <= hwdata[nv_access_pkg::BIT_READY_IRQ_EN];
    end
  end

  // Address changes refused while programming
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nv_byte_address_r <= nv_access_pkg::ADDR_RESET;
    end else if (act & hit(dp_addr_r, nv_access_pkg::OFS_ADDR) &
                 ~busy) begin
      nv_byte_address_r <= hwdata[AW-1:0];
    end
  end

  // Data register: software byte, or array byte on a read strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nv_byte_value_r <= nv_access_pkg::DATA_RESET;
    end else if (rd_req) begin
      nv_byte_value_r <= array_r[nv_byte_address_r];
    end else if (act & hit(dp_addr_r, nv_access_pkg::OFS_DATA)) begin
      nv_byte_value_r <= hwdata[DW-1:0];
    end
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= '0;
    end else if (act & hit(dp_addr_r, nv_access_pkg::OFS_STAT)) begin
      stat_r <= (stat_r & ~hwdata[SW-1:0]) | stat_set;
    end else begin
      stat_r <= stat_r | stat_set;
    end
  end

  // Interrupt mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_r <= '0;
    end else if (act & hit(dp_addr_r, nv_access_pkg::OFS_MASK)) begin
      mask_r <= hwdata[SW-1:0];
    end
  end

  // Ready level is gated by the core's global enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (ready_irq_enable_r & ~busy & global_irq_en) |
             (|(stat_r & mask_r));
    end
  end

  // Mode field; system reset only clears it when idle, so a
  // programming cycle in flight keeps its mode across the reset
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      op_mode_r <= nv_access_pkg::MODE_RESET;
    end else if (!hresetn) begin
      if (!busy) begin
        op_mode_r <= nv_access_pkg::MODE_RESET;
      end
    end else if (wr_ctrl & ~busy) begin
      op_mode_r <= new_mode;
    end
  end

  // Programming engine; the strobe bit reads as busy
  always_ff @(posedge hclk or negedge por_n) begin
    if (!por_n) begin
      eng_state_r <= ENG_IDLE;
      timer_r <= '0;
      op_r <= nv_access_pkg::MODE_ATOMIC;
      prog_addr_r <= nv_access_pkg::ADDR_RESET;
      prog_data_r <= nv_access_pkg::DATA_RESET;
    end else begin
      case (eng_state_r)
        ENG_IDLE: begin
          if (prog_go & hresetn) begin
            eng_state_r <= ENG_BUSY;
            op_r <= new_mode;
            timer_r <= prog_cycles(new_mode);
            prog_addr_r <= nv_byte_address_r;
            prog_data_r <= nv_byte_value_r;
          end
        end
        ENG_BUSY: begin
          if (prog_done) begin
            eng_state_r <= ENG_IDLE;
          end
          timer_r <= timer_r - TW'(1);
        end
        default: begin
          eng_state_r <= ENG_IDLE;
        end
      endcase
    end
  end

  // Array cells; no reset, the contents are meant to persist
  always_ff @(posedge hclk) begin
    if (prog_done) begin
      case (op_r)
        nv_access_pkg::MODE_ATOMIC: begin
          array_r[prog_addr_r] <= prog_data_r;
        end
        nv_access_pkg::MODE_ERASE: begin
          array_r[prog_addr_r] <= nv_access_pkg::ERASED_BYTE;
        end
        nv_access_pkg::MODE_WRITE: begin
          // Write only can clear bits, never set them
          array_r[prog_addr_r] <= array_r[prog_addr_r] & prog_data_r;
        end
        default: begin
          array_r[prog_addr_r] <= array_r[prog_addr_r];
        end
      endcase
    end
  end

endmodule

// [test/nv_access_control_assertions.sv]
/*
  Concurrent checks on the nonvolatile access controller's ports.
  Assumes hready is the controller's own hreadyout and one hclk domain.
*/
`timescale 1ns/1ps
module nv_access_control_assertions (
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Bus reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic irq // Level interrupt
);
  logic fst_r;
  logic [2:0] arm_cnt_r;
  wire logic act = hsel && htrans[1] && hready;
  wire logic rd_ctrl = act && !hwrite && haddr[7:0] == 8'h00;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // First data-phase cycle of a control write, and the arm window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fst_r <= 1'b0;
      arm_cnt_r <= 3'h0;
    end else begin
      fst_r <= act && hwrite && haddr[7:0] == nv_access_pkg::OFS_CTRL;
      if (fst_r && hwdata[nv_access_pkg::BIT_PROG_ARM])
        arm_cnt_r <= 3'h4; // Counted from the write edge, not hready
      else if (arm_cnt_r != 3'h0)
        arm_cnt_r <= arm_cnt_r - 3'h1;
    end
  end

  a_stall_ctrl_only: assert property ($fell(hreadyout) |-> fst_r)
    else $error("stall outside a control write");
  a_prog_stall_two: assert property ($fell(hreadyout) && !hwdata[0]
    |=> !hreadyout ##1 hreadyout) else $error("program stall length");
  a_read_stall_four: assert property ($fell(hreadyout) && hwdata[0]
    |=> !hreadyout [*3] ##1 hreadyout) else $error("read stall length");
  a_prog_needs_arm: assert property ($fell(hreadyout) && !hwdata[0]
    |-> arm_cnt_r != 3'h0) else $error("program started unarmed");
  a_arm_expires: assert property (rd_ctrl && arm_cnt_r == 3'h0
    |=> !hrdata[2]) else $error("arm bit outlived its window");
  a_arm_window: assert property (rd_ctrl && arm_cnt_r != 3'h0
    |=> hrdata[2]) else $error("arm bit cleared too early");
  a_ctrl_upper_zero: assert property (rd_ctrl
    |=> hrdata[31:6] == 26'h0 && !hrdata[0]) else $error("control bits");
  a_addr_nine_bits: assert property (act && !hwrite
    && haddr[7:0] == 8'h04 |=> hrdata[31:9] == 23'h0)
    else $error("address wider than nine bits");
  a_hrdata_holds: assert property ($changed(hrdata)
    |-> $past(act && !hwrite)) else $error("read data moved");

  c_read_stall: cover property ($fell(hreadyout) && hwdata[0]);
  c_prog_stall: cover property ($fell(hreadyout) && !hwdata[0]);
  c_irq_rise: cover property ($rose(irq));
endmodule

bind nv_access_control nv_access_control_assertions chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .irq(irq)
);

// [test/nv_access_control_tb.sv]
/*
  Self-checking bench for the nonvolatile access controller.
  Assumes the checker file is compiled alongside; short timing counts.
*/
`timescale 1ns/1ps
module nv_access_control_tb;
  typedef struct {logic [31:0] v; logic [31:0] m;} note_t;
  localparam int A = 40;
  localparam int S = 20;
  localparam logic [7:0] CT = nv_access_pkg::OFS_CTRL;
  localparam logic [7:0] AD = nv_access_pkg::OFS_ADDR;
  localparam logic [7:0] DT = nv_access_pkg::OFS_DATA;
  localparam logic [7:0] ST = nv_access_pkg::OFS_STAT;
  localparam logic [7:0] MK = nv_access_pkg::OFS_MASK;
  localparam logic [7:0] DAT [4] = '{8'h5A, 8'h11, 8'h3C, 8'h00};
  localparam logic [7:0] RES [4] = '{8'h5A, 8'hFF, 8'h3C, 8'h3C};
  logic hclk, hresetn, por_n, hsel, hwrite, hreadyout, hresp, irq;
  logic global_irq_en, rp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [7:0] dv;
  integer seed;
  int bad_count, cmp_count, st;
  note_t q[$];
  note_t n;

  nv_access_control #(.ATOMIC_CYCLES(A), .SPLIT_CYCLES(S)) dut (
    .hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .global_irq_en(global_irq_en),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq)
  );

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One single AHB transfer; st counts stalled data-phase cycles
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    st = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      st++;
      @(posedge hclk);
    end
    rd = hrdata;
  endtask

  // Read with a note of the expected bits for the monitor
  task automatic rc(input logic [7:0] a, input logic [31:0] v,
                    input logic [31:0] m);
    q.push_back('{v: v & m, m: m});
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic irqchk(input logic e);
    repeat (2) @(posedge hclk);
    check(irq, e);
  endtask

  // Arm, strobe, probe the busy refusals, then time the busy span
  task automatic prog(input logic [1:0] md);
    int t0;
    int el;
    xfer(1'b1, CT, 32'h4);
    xfer(1'b1, CT, {26'h0, md, 4'h2});
    check(st, (md == 2'h3) ? 0 : 2);
    if (md != 2'h3) begin
      t0 = int'($time);
      xfer(1'b1, AD, 32'h0);
      check(hresp, 32'h0);
      xfer(1'b1, CT, 32'h31);
      check(st, 0);
      rc(AD, 32'h1FF, 32'h1FF);
      rc(CT, {26'h0, md, 4'h2}, 32'h32);
      do xfer(1'b0, CT, 32'h0); while (rd[1] === 1'b1);
      el = (int'($time) - t0) / 10;
      check(el >= (md ? S : A) - 2 && el <= (md ? S : A) + 3, 1);
    end else begin
      rc(CT, 32'h0, 32'h2);
    end
  endtask

  // Monitor: takes the oldest note when a read data phase completes
  always @(posedge hclk) begin
    if (rp && hreadyout && q.size() > 0) begin
      n = q.pop_front();
      check(hrdata & n.m, n.v);
    end
    if (hreadyout)
      rp <= hsel && htrans[1] && !hwrite;
  end

  // Watchdog, well beyond the expected run length
  initial begin
    repeat (5000) @(posedge hclk);
    bad_count++;
    summarize;
  end

  initial begin
    seed = 32'h42F8001B;
    {hresetn, por_n, hsel, hwrite, global_irq_en} = 5'h00;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge hclk);
    rc(CT, 32'h0, 32'h3F);
    xfer(1'b1, 8'h14, 32'hFFFFFFFF);
    rc(8'h14, 32'h0, 32'hFFFFFFFF);
    xfer(1'b1, AD, 32'hFFFFFFFF);
    rc(AD, 32'h1FF, 32'hFFFFFFFF);
    repeat (6) begin
      dv = 8'($random(seed));
      xfer(1'b1, DT, {24'h0, dv});
      rc(DT, {24'h0, dv}, 32'hFFFFFFFF);
    end
    // Arm reads set for four edges, then clears
    xfer(1'b1, CT, 32'h4);
    rc(CT, 32'h4, 32'h4);
    rc(CT, 32'h4, 32'h4);
    rc(CT, 32'h0, 32'h4);
    xfer(1'b1, CT, 32'h2);
    check(st, 0);
    rc(ST, 32'h2, 32'h3);
    xfer(1'b1, ST, 32'h3);
    rc(ST, 32'h0, 32'h3);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, DT, {24'h0, DAT[i]});
      prog(i[1:0]);
      xfer(1'b1, CT, 32'h1);
      check(st, 4);
      rc(DT, {24'h0, RES[i]}, 32'hFF);
    end
    // Reset in mid-programming keeps the mode
    xfer(1'b1, CT, 32'h4);
    xfer(1'b1, CT, 32'h22);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(CT, 32'h22, 32'h32);
    do xfer(1'b0, CT, 32'h0); while (rd[1] === 1'b1);
    global_irq_en <= 1'b1;
    xfer(1'b1, CT, 32'h8);
    irqchk(1'b1);
    xfer(1'b1, CT, 32'h0);
    irqchk(1'b0);
    xfer(1'b1, MK, 32'h1);
    irqchk(1'b1);
    xfer(1'b1, ST, 32'h3);
    irqchk(1'b0);
    xfer(1'b1, CT, 32'h28);
    global_irq_en <= 1'b0;
    irqchk(1'b0);
    // Reset while idle must clear the mode field
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(CT, 32'h0, 32'h3A);
    repeat (2) @(posedge hclk);
    summarize;
  end
endmodule
